// [include/cpsf_params.svh]
// timing counts and reset values of the comparator stretch and filter block
`ifndef CPSF_PARAMS_SVH
`define CPSF_PARAMS_SVH

`define CPSF_STRETCH_MIN_CYCLES 2'h3
`define CPSF_FILTER_STABLE_LEN  3
`define CPSF_HIST_ALL_HIGH      3'h7
`define CPSF_HIST_ALL_LOW       3'h0
`define CPSF_RST_LEVEL          1'h0
`define CPSF_RST_COUNT          2'h0
`define CPSF_RST_HIST           3'h0

`endif

// [include/cpsf_pkg.sv]
// types of the comparator stretch and filter block
package cpsf_pkg;

	typedef logic [1:0] cpsf_count_t;
	typedef logic [2:0] cpsf_hist_t;

	// clocked state of the block, except the stretch flag holdFlag
	typedef struct packed {
		cpsf_count_t stretchCnt;
		logic        sync1;
		logic        sync2;
		cpsf_hist_t  hist;
		logic        filtLevel;
		logic        cmpOut;
	} cpsf_state_s;

endpackage

// [design/cpsf_comparator_filter.sv]
// comparator pulse stretcher followed by the optional digital filter
//
// Overview of operation
// RQ1: apply selectable polarity to raw comparator
// RQ2: polarised signal enters the pulse stretcher
// RQ3: stretcher sets asynchronously on active input
// RQ4: stretched output held at least three cycles
// RQ5: digital filter follows the stretcher through two sync stages
// RQ6: filter works only while enable bit set
// RQ7: filter samples on the selected filter clock
// RQ8: new level needs three stable filter samples
// RQ9: disabled passes through; enabled holds old level
`timescale 1ns/1ns
`include "cpsf_params.svh"

module cpsf_comparator_filter (
	input  wire logic mclk,
	input  wire logic rst_n,
	input  wire logic cmpRaw,
	input  wire logic invertPolarity,
	input  wire logic filterEnable,
	input  wire logic filterClockSelect,
	input  wire logic filterTick,
	output logic      stretchOut,
	output logic      cmpOut
);

	// internal nets of the stretch and filter paths
	logic                 polarised;
	logic                 holdFlag;
	logic                 stretchDone;
	logic                 sampleTick;
	cpsf_pkg::cpsf_state_s st;
	cpsf_pkg::cpsf_state_s next_st;

	// polarity applied before anything digital looks at it
	assign polarised = cmpRaw ^ invertPolarity; // [RQ1]

	// release only once the minimum width has run and the input is gone
	assign stretchDone = (st.stretchCnt == `CPSF_STRETCH_MIN_CYCLES) &&
		!polarised;

	// async set catches transients shorter than a clock period;
	// kept apart from the state struct because it has its own set path
	// limitation: the set input is the raw pin path, so a glitch on it
	// lands directly on the flag; the two-stage resynchroniser below is
	// what keeps a metastable flag away from the filter
	always_ff @(posedge mclk or posedge polarised or negedge rst_n) begin
		if (!rst_n) begin
			holdFlag <= `CPSF_RST_LEVEL;
		end else if (polarised) begin
			holdFlag <= 1'b1; // [RQ2] [RQ3]
		end else if (stretchDone) begin
			holdFlag <= 1'b0; // [RQ4]
		end
	end

	// filter clock: every system clock, or the alternate tick input
	// the tick must be a single-cycle pulse in the mclk domain; a held
	// tick makes the filter run at full rate
	assign sampleTick = filterClockSelect ? filterTick : 1'b1; // [RQ7]

	// next state of counter, synchroniser and filter
	always_comb begin
		next_st = st;
		// width counter runs while stretched, saturates at the minimum
		if (!holdFlag) begin
			next_st.stretchCnt = `CPSF_RST_COUNT;
		end else if (st.stretchCnt != `CPSF_STRETCH_MIN_CYCLES) begin
			next_st.stretchCnt = st.stretchCnt + 2'h1; // [RQ4]
		end
		// holdFlag is set asynchronously, so resynchronise it
		next_st.sync1 = holdFlag;
		next_st.sync2 = st.sync1;
		// history only moves while enabled and on a filter clock
		if (filterEnable && sampleTick) begin
			next_st.hist = {st.hist[1:0], st.sync2}; // [RQ5] [RQ6] [RQ7]
		end
		// level changes only when the whole history agrees
		if (next_st.hist == `CPSF_HIST_ALL_HIGH) begin
			next_st.filtLevel = 1'b1; // [RQ8]
		end else if (next_st.hist == `CPSF_HIST_ALL_LOW) begin
			next_st.filtLevel = 1'b0; // [RQ8]
		end
		// bypass when disabled, otherwise the held filter level
		next_st.cmpOut = filterEnable ? next_st.filtLevel : st.sync2; // [RQ9]
	end

	// single state register
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st.stretchCnt <= `CPSF_RST_COUNT;
			st.sync1      <= `CPSF_RST_LEVEL;
			st.sync2      <= `CPSF_RST_LEVEL;
			st.hist       <= `CPSF_RST_HIST;
			st.filtLevel  <= `CPSF_RST_LEVEL;
			st.cmpOut     <= `CPSF_RST_LEVEL;
		end else begin
			st <= next_st;
		end
	end

	assign stretchOut = st.sync2; // synchronised stretched level
	assign cmpOut     = st.cmpOut;

	// checks
	// properties see sampled values: the stretch flag can rise between
	// edges, so checks on it hold from the first edge that samples it;
	// a transient fully inside one cycle is seen only through the flag
	a_polarity_sets_hold: assert property ( // [RQ1]
		@(posedge mclk) disable iff (!rst_n)
		(cmpRaw ^ invertPolarity) |-> holdFlag)
		else $error("polarised input high without stretch flag");

	a_quiet_stretch_out: assert property ( // [RQ2]
		@(posedge mclk) disable iff (!rst_n)
		(!holdFlag) [*3] |-> !stretchOut)
		else $error("stretched output high with no stretch event");

	a_async_set_seen: assert property ( // [RQ3]
		@(posedge mclk) disable iff (!rst_n)
		$rose(polarised) |-> holdFlag ##2 stretchOut)
		else $error("active input not stretched to output");

	a_min_stretch_width: assert property ( // [RQ4]
		@(posedge mclk) disable iff (!rst_n)
		$rose(holdFlag) |-> holdFlag [*3])
		else $error("stretch shorter than three cycles");

	a_filter_drives_out: assert property ( // [RQ5]
		@(posedge mclk) disable iff (!rst_n)
		filterEnable |=> (cmpOut == st.filtLevel))
		else $error("enabled output differs from filter level");

	a_bypass_when_off: assert property ( // [RQ6]
		@(posedge mclk) disable iff (!rst_n)
		!filterEnable |=> (cmpOut == $past(stretchOut)))
		else $error("disabled filter does not pass through");

	a_tick_gates_hist: assert property ( // [RQ7]
		@(posedge mclk) disable iff (!rst_n)
		!(filterEnable && sampleTick) |=> $stable(st.hist))
		else $error("history moved without filter clock");

	a_three_stable: assert property ( // [RQ8]
		@(posedge mclk) disable iff (!rst_n)
		$changed(st.filtLevel) |->
			(st.hist == {`CPSF_FILTER_STABLE_LEN{st.filtLevel}}))
		else $error("filter level changed without stable history");

	a_hold_mixed: assert property ( // [RQ9]
		@(posedge mclk) disable iff (!rst_n)
		(filterEnable && st.hist != `CPSF_HIST_ALL_HIGH &&
			st.hist != `CPSF_HIST_ALL_LOW && !sampleTick)
			|=> $stable(cmpOut))
		else $error("enabled output moved on mixed history");

	// stretch path, one edge per stage
	a_sync_first_stage: assert property ( // [RQ2]
		@(posedge mclk) disable iff (!rst_n)
		holdFlag |=> st.sync1)
		else $error("first sync stage missed stretch flag");

	a_sync_second_stage: assert property ( // [RQ2]
		@(posedge mclk) disable iff (!rst_n)
		st.sync1 |=> stretchOut)
		else $error("stretched output missed first stage");

	// an input still active at an edge keeps the flag up
	a_active_keeps_flag: assert property ( // [RQ3]
		@(posedge mclk) disable iff (!rst_n)
		polarised |=> holdFlag)
		else $error("stretch flag dropped while input active");

	// counter is idle whenever the flag is low
	a_count_idle_low: assert property ( // [RQ4]
		@(posedge mclk) disable iff (!rst_n)
		!holdFlag |=> (st.stretchCnt == `CPSF_RST_COUNT))
		else $error("width counter ran without stretch flag");

	// release only after the full minimum count
	a_release_after_count: assert property ( // [RQ4]
		@(posedge mclk) disable iff (!rst_n)
		$fell(holdFlag) |->
			($past(st.stretchCnt) == `CPSF_STRETCH_MIN_CYCLES))
		else $error("stretch released before minimum count");

	a_out_width_three: assert property ( // [RQ4]
		@(posedge mclk) disable iff (!rst_n)
		$rose(stretchOut) |-> stretchOut [*3])
		else $error("stretched output shorter than three cycles");

	// nothing moves in the filter while it is switched off
	a_off_hist_frozen: assert property ( // [RQ6]
		@(posedge mclk) disable iff (!rst_n)
		!filterEnable |=> ($stable(st.hist) && $stable(st.filtLevel)))
		else $error("filter state moved while disabled");

	// with the alternate clock chosen, only a tick may move the level
	a_level_waits_tick: assert property ( // [RQ7]
		@(posedge mclk) disable iff (!rst_n)
		(filterClockSelect && !filterTick) |=> $stable(st.filtLevel))
		else $error("filter level moved without a tick");

	// main scenarios
	c_stretch_event: cover property (
		@(posedge mclk) disable iff (!rst_n) $rose(stretchOut));

	c_filter_rise: cover property (
		@(posedge mclk) disable iff (!rst_n)
		filterEnable && $rose(cmpOut));

	c_slow_clock_fall: cover property (
		@(posedge mclk) disable iff (!rst_n)
		filterEnable && filterClockSelect && $fell(cmpOut));

	// slow clock gap with a mixed history, the case the filter rejects
	c_mixed_hold: cover property (
		@(posedge mclk) disable iff (!rst_n)
		filterEnable && !sampleTick && (st.hist == 3'h3));
	c_wide_stretch: cover property (
		@(posedge mclk) disable iff (!rst_n)
		polarised && (st.stretchCnt == `CPSF_STRETCH_MIN_CYCLES));

endmodule // cpsf_comparator_filter

// [test/cpsf_fault_sink.sv]
// downstream fault logic model that latches and counts comparator events
`timescale 1ns/1ns

module cpsf_fault_sink (
	input  wire logic       mclk,
	input  wire logic       rst_n,
	input  wire logic       faultIn,
	output logic      [7:0] faultCount
);
	logic prevIn;
	// one count per rising edge, as a fault latch would see it
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			prevIn <= 1'h0;
			faultCount <= 8'h00;
		end else begin
			prevIn <= faultIn;
			if (faultIn && !prevIn) faultCount <= faultCount + 8'h01;
		end
	end
endmodule // cpsf_fault_sink

// [test/cpsf_comparator_filter_test.sv]
// scenario bench of the comparator stretch and filter block
`timescale 1ns/1ns

module cpsf_comparator_filter_test;
	logic mclk = 0, rst_n = 0, cmpRaw = 0, invertPolarity = 0;
	logic filterEnable = 0, filterClockSelect = 0, filterTick = 0;
	logic stretchOut, cmpOut;
	logic [7:0] faultCount;
	int fail_count = 0, total_checks = 0, cycles = 0;
	cpsf_comparator_filter dut_u (.mclk(mclk), .rst_n(rst_n),
		.cmpRaw(cmpRaw), .invertPolarity(invertPolarity),
		.filterEnable(filterEnable), .filterClockSelect(filterClockSelect),
		.filterTick(filterTick), .stretchOut(stretchOut), .cmpOut(cmpOut));
	cpsf_fault_sink sink_u (.mclk(mclk), .rst_n(rst_n), .faultIn(cmpOut),
		.faultCount(faultCount));
	initial forever #5 mclk = ~mclk;
	// hang guard, far above the 160 or so cycles the run needs
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 2000) begin
			fail_count++;
			end_sim();
		end
	end
	task chk(input logic got, input logic exp, input string what);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED %0t %s", $time, what);
		end
	endtask
	// sub-cycle glitch, off the edge on purpose: the set is asynchronous
	task pulse();
		@(posedge mclk);
		#3 cmpRaw = ~invertPolarity;
		#2 cmpRaw = invertPolarity;
	endtask
	task edges(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task t_bypass();
		pulse();
		edges(2); chk(stretchOut, 1'h1, "stretch set");
		edges(1); chk(cmpOut, 1'h1, "bypass follow");
		edges(2); chk(stretchOut, 1'h1, "stretch held");
		edges(1); chk(stretchOut, 1'h0, "stretch end");
		edges(1); chk(cmpOut, 1'h0, "bypass clear");
		edges(4); $display("test bypass done");
	endtask
	task t_polarity();
		@(posedge mclk); invertPolarity <= 1'h1; cmpRaw <= 1'h1;
		edges(8); chk(cmpOut, 1'h0, "inverted idle");
		pulse();
		edges(2); chk(stretchOut, 1'h1, "inverted set");
		edges(10); invertPolarity <= 1'h0; cmpRaw <= 1'h0;
		edges(10); $display("test polarity done");
	endtask
	task t_filter(input logic sel, input logic tick, input logic exp);
		@(posedge mclk); filterEnable <= 1'h1;
		filterClockSelect <= sel; filterTick <= tick;
		pulse();
		edges(4); chk(cmpOut, 1'h0, "filter early");
		edges(1); chk(cmpOut, exp, "filter pass");
		edges(3); chk(cmpOut, exp, "filter hold");
		edges(12); filterTick <= 1'h0; filterEnable <= 1'h0;
		edges(4); $display("test filter done");
	endtask
	// input held past the minimum width stretches the output further
	task t_wide();
		@(posedge mclk); cmpRaw <= 1'h1;
		repeat (6) @(posedge mclk);
		cmpRaw <= 1'h0;
		edges(2); chk(stretchOut, 1'h1, "wide held");
		edges(1); chk(stretchOut, 1'h0, "wide end");
		edges(1); chk(cmpOut, 1'h0, "wide bypass clear");
		edges(4); $display("test wide done");
	endtask
	// slow filter clock: three samples span six cycles, so a short
	// stretch that passes at full rate must be rejected here
	task t_slow();
		@(posedge mclk); filterEnable <= 1'h1;
		filterClockSelect <= 1'h1; filterTick <= 1'h0;
		pulse();
		repeat (8) begin
			@(posedge mclk); filterTick <= ~filterTick;
		end
		edges(1); chk(cmpOut, 1'h0, "slow reject");
		@(posedge mclk); filterEnable <= 1'h0;
		filterClockSelect <= 1'h0;
		edges(4); $display("test slow done");
	endtask
	task end_sim();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge mclk);
		rst_n <= 1'h1;
		edges(2);
		t_bypass();
		t_wide();
		t_polarity();
		t_filter(1'h0, 1'h0, 1'h1);
		t_filter(1'h1, 1'h0, 1'h0);
		t_filter(1'h1, 1'h1, 1'h1);
		t_slow();
		chk(faultCount == 8'h05, 1'h1, "event count");
		end_sim();
	end
endmodule // cpsf_comparator_filter_test
